// ### inc/ssar_pkg.sv
/*
  Constants, types and register limits and defaults for the speed search and
  auto-restart controller. Assumes a 50 MHz system clock and a register
  port with 16-bit data and byte addresses in steps of four.
*/
// Contract
// - Search mask bits: accel, fault, power-fail, power-on
// - Search current limit 80..200 percent, default 100
// - PI gains: P 0..9999 (100), I 0..3333 (1000)
// - Output function 15 flags active search
// - Power loss raises undervoltage trip, holds output
// - Power back: resume saved frequency, ramp voltage
// - Over current limit: stop voltage, lower frequency
// - Under limit again: raise voltage, stop lowering
// - Nominal reached: end search, accelerate to goal
// - Retry count 0..10 (0), delay 0..60 s (1.0)
// - After trip wait delay, retry, decrement count
// - Count exhausted: no automatic restart
// - Terminal or key reset reloads retry count
// - No trip for 30 s restores retry count
// - Undervoltage or emergency halt inhibits auto restart
// - Delay expiry restarts through speed search
// - Energy saving trims voltage 0..30 percent
// - Vector mode magnetizes with no-load current first
// - Reset loads motor defaults per rating
// - Control mode 3 selects sensorless vector
package ssar_pkg;

  localparam int DW = 16;
  localparam int AW = 8;

  typedef logic [DW-1:0] ssar_word_t;

  typedef struct packed {
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic wr;
    logic rd;
  } ssar_bus_req_t;

  typedef struct packed {
    logic [DW-1:0] freq;
    logic [DW-1:0] volt;
    logic [DW-1:0] magCur;
  } ssar_drive_t;

  // Slip 0.1 Hz, current 0.1 A, no-load 0.01 A, resistance mOhm, inductance 0.01 mH
  typedef struct packed {
    logic [DW-1:0] slip;
    logic [DW-1:0] cur;
    logic [DW-1:0] noLoad;
    logic [DW-1:0] rs;
    logic [DW-1:0] ls;
  } ssar_motor_t;

  typedef enum logic [2:0] {ST_IDLE, ST_MAG, ST_SEARCH, ST_RUN, ST_RWAIT, ST_TRIP} ssar_state_t;

  localparam logic [AW-1:0] OFS_SEARCH_CFG = 8'h00;
  localparam logic [AW-1:0] OFS_CUR_LIMIT = 8'h04;
  localparam logic [AW-1:0] OFS_PROP_GAIN = 8'h08;
  localparam logic [AW-1:0] OFS_INT_GAIN = 8'h0c;
  localparam logic [AW-1:0] OFS_RETRY_CNT = 8'h10;
  localparam logic [AW-1:0] OFS_RETRY_DLY = 8'h14;
  localparam logic [AW-1:0] OFS_SAVING = 8'h18;
  localparam logic [AW-1:0] OFS_MAG_TIME = 8'h1c;
  localparam logic [AW-1:0] OFS_RATING = 8'h20;
  localparam logic [AW-1:0] OFS_SLIP = 8'h24;
  localparam logic [AW-1:0] OFS_RATED_CUR = 8'h28;
  localparam logic [AW-1:0] OFS_NOLOAD_CUR = 8'h2c;
  localparam logic [AW-1:0] OFS_STATOR_R = 8'h30;
  localparam logic [AW-1:0] OFS_LEAK_L = 8'h34;
  localparam logic [AW-1:0] OFS_COMMAND = 8'h38;
  localparam logic [AW-1:0] OFS_STATUS = 8'h3c;
  localparam logic [AW-1:0] OFS_OUT_FUNC = 8'h40;

  localparam int SS_ACCEL = 0;
  localparam int SS_FAULT = 1;
  localparam int SS_POWER = 2;
  localparam int SS_POWERON = 3;
  localparam int CMD_START = 0;
  localparam int CMD_RESET = 1;
  localparam int CMD_ACCEL = 2;
  localparam int CMD_STOP = 3;

  localparam ssar_word_t CUR_LIMIT_MIN = 16'h0050;
  localparam ssar_word_t CUR_LIMIT_MAX = 16'h00c8;
  localparam ssar_word_t CUR_LIMIT_RST = 16'h0064;
  localparam ssar_word_t PROP_GAIN_MAX = 16'h270f;
  localparam ssar_word_t PROP_GAIN_RST = 16'h0064;
  localparam ssar_word_t INT_GAIN_MAX = 16'h0d05;
  localparam ssar_word_t INT_GAIN_RST = 16'h03e8;
  localparam ssar_word_t RETRY_CNT_MAX = 16'h000a;
  localparam ssar_word_t RETRY_CNT_RST = 16'h0000;
  localparam ssar_word_t RETRY_DLY_MAX = 16'h0258;
  localparam ssar_word_t RETRY_DLY_RST = 16'h000a;
  localparam ssar_word_t SAVING_MAX = 16'h001e;
  localparam ssar_word_t SAVING_RST = 16'h0000;
  localparam ssar_word_t MAG_TIME_MAX = 16'h0258;
  localparam ssar_word_t MAG_TIME_RST = 16'h000a;
  localparam ssar_word_t RATING_MAX = 16'h0004;
  localparam ssar_word_t RATING_RST = 16'h0000;
  localparam ssar_word_t MODE_MAX = 16'h0003;
  localparam logic [1:0] MODE_VECTOR = 2'h3;
  localparam logic [4:0] FUNC_SEARCH = 5'h0f;
  localparam logic [4:0] OUT_FUNC_RST = 5'h0c;
  localparam logic [4:0] RELAY_FUNC_RST = 5'h11;
  localparam logic [16:0] PCT_FULL = 17'h00064;
  localparam ssar_word_t FREQ_STEP = 16'h0001;
  localparam int PI_SHIFT = 8;

  localparam int CLK_HZ = 50_000_000;
  localparam int TICK_TIME_MS = 1;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_TIME_MS;
  localparam int TENTH_TIME_MS = 100;
  localparam logic [6:0] MS_PER_TENTH = 7'(TENTH_TIME_MS / TICK_TIME_MS);
  localparam int RESTORE_TIME_S = 30;
  localparam logic [8:0] RESTORE_TENTHS = 9'(RESTORE_TIME_S * 10);

endpackage : ssar_pkg

// ### src/ssar_ctrl.sv
/*
  Speed search, auto-restart and motor parameter control of a drive.
  Assumes feedback inputs synchronous to clk, current in 0.1 A, frequency
  in 0.01 Hz, and a register master that never waits.
*/
// Implementation choices: the placing of the registers and the plain strobed port.
`timescale 1ns/10ps
module ssar_ctrl
  import ssar_pkg::*;
#(
  parameter int unsigned TICK_CYC = TICK_CYCLES
) (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  // Register port
  input wire ssar_bus_req_t busReq,
  output ssar_word_t rdData,
  // Drive feedback and terminals
  input wire logic [DW-1:0] outCurrent,
  input wire logic [DW-1:0] targetFreq,
  input wire logic [DW-1:0] maxVolt,
  input wire logic powerLoss,
  input wire logic faultTrip,
  input wire logic emergencyHalt,
  input wire logic resetTerminal,
  // Drive and signal outputs
  output ssar_drive_t drive,
  output logic programmableOutput,
  output logic programmableRelay,
  output logic undervoltageTrip,
  output logic magnetizing
);

  logic [1:0] rstSync_ff;
  logic rst_n;
  logic [31:0] msCnt_ff;
  logic msTick_ff;
  logic [6:0] tenthCnt_ff;
  logic tenthTick_ff;
  logic [3:0] searchMask_ff;
  logic [1:0] ctrlMode_ff;
  ssar_word_t curLimit_ff, propGain_ff, intGain_ff, retryCfg_ff, retryDelay_ff;
  ssar_word_t saving_ff, magTime_ff, rating_ff;
  ssar_motor_t motor_ff;
  logic [4:0] outFunc_ff, relayFunc_ff;
  ssar_state_t state_ff;
  ssar_word_t freq_ff, volt_ff, savedFreq_ff, goalFreq_ff, timer_ff;
  logic signed [23:0] integ_ff;
  logic uvTrip_ff;
  logic [3:0] remaining_ff;
  logic inhibit_ff;
  logic restoreActive_ff;
  logic [8:0] restoreCnt_ff;
  logic restoreDone_ff;
  logic resetTermPrev_ff;
  ssar_word_t rdData_ff;
  ssar_drive_t drive_ff;
  logic progOut_ff, progRelay_ff, magnetizing_ff;

  logic cmdWr, startCmd, stopCmd, accelCmd, resetEv;
  logic busy, emgEv, lossEv, faultEv, attemptEv;
  logic [31:0] limitProd;
  ssar_word_t limitCur, vTarget;
  logic overLimit;
  logic signed [16:0] piErr;
  logic signed [47:0] piSum;
  ssar_word_t piStep;
  logic [16:0] voltSum;
  logic [31:0] saveProd;

  function automatic ssar_word_t clampW(input ssar_word_t v, input ssar_word_t lo,
                                        input ssar_word_t hi);
    clampW = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : clampW

  function automatic ssar_motor_t motorDefaults(input ssar_word_t r);
    case (r)
      16'h0001: motorDefaults = '{16'd18, 16'd11, 16'd300, 16'd6700, 16'd6158};
      16'h0002: motorDefaults = '{16'd35, 16'd21, 16'd233, 16'd2460, 16'd2814};
      16'h0003: motorDefaults = '{16'd65, 16'd35, 16'd233, 16'd1130, 16'd1475};
      16'h0004: motorDefaults = '{16'd88, 16'd44, 16'd200, 16'd869, 16'd1131};
      default: motorDefaults = '{16'd9, 16'd5, 16'd300, 16'd14000, 16'd12200};
    endcase
  endfunction : motorDefaults

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rstSync_ff <= 2'b00;
    end else begin
      rstSync_ff <= {rstSync_ff[0], 1'b1};
    end
  end
  assign rst_n = rstSync_ff[1];

  // Millisecond control tick and tenth-second timing tick
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      msCnt_ff <= 32'h0;
      msTick_ff <= 1'b0;
      tenthCnt_ff <= 7'h0;
      tenthTick_ff <= 1'b0;
    end else if (ce) begin
      msTick_ff <= (msCnt_ff == TICK_CYC - 1);
      msCnt_ff <= (msCnt_ff == TICK_CYC - 1) ? 32'h0 : msCnt_ff + 32'h1;
      tenthTick_ff <= msTick_ff && (tenthCnt_ff == MS_PER_TENTH - 7'h1);
      if (msTick_ff) begin
        tenthCnt_ff <= (tenthCnt_ff == MS_PER_TENTH - 7'h1) ? 7'h0 : tenthCnt_ff + 7'h1;
      end
    end
  end

  assign cmdWr = busReq.wr && (busReq.addr == OFS_COMMAND);
  assign startCmd = cmdWr && busReq.wdata[CMD_START];
  assign stopCmd = cmdWr && busReq.wdata[CMD_STOP];
  assign accelCmd = cmdWr && busReq.wdata[CMD_ACCEL];
  assign resetEv = (cmdWr && busReq.wdata[CMD_RESET]) || (resetTerminal && !resetTermPrev_ff);
  assign busy = (state_ff == ST_MAG) || (state_ff == ST_SEARCH) || (state_ff == ST_RUN);
  assign emgEv = emergencyHalt && (busy || state_ff == ST_RWAIT);
  assign lossEv = powerLoss && !emgEv && (busy || state_ff == ST_RWAIT);
  assign faultEv = faultTrip && busy && !emgEv && !lossEv;
  assign attemptEv = (state_ff == ST_RWAIT) && (timer_ff == 16'h0) && !emgEv && !lossEv &&
                     !resetEv;

  // Search current limit as a share of rated current
  assign limitProd = 32'(motor_ff.cur * curLimit_ff);
  assign limitCur = 16'(limitProd / 32'(PCT_FULL));
  assign overLimit = outCurrent > limitCur;
  assign saveProd = 32'(maxVolt * (PCT_FULL[15:0] - saving_ff));
  assign vTarget = 16'(saveProd / 32'(PCT_FULL));
  assign piErr = $signed({1'b0, limitCur}) - $signed({1'b0, outCurrent});
  assign piSum = 48'($signed({1'b0, propGain_ff}) * piErr) +
                 48'($signed({1'b0, intGain_ff}) * integ_ff);
  assign piStep = (piSum <= 48'sh0) ? 16'h1 :
                  ((piSum >>> PI_SHIFT) > 48'sh7fff) ? 16'h7fff : 16'(piSum >>> PI_SHIFT);
  assign voltSum = {1'b0, volt_ff} + {1'b0, piStep};

  // Settings, each held inside its legal range
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      searchMask_ff <= 4'h0;
      ctrlMode_ff <= 2'h0;
      curLimit_ff <= CUR_LIMIT_RST;
      propGain_ff <= PROP_GAIN_RST;
      intGain_ff <= INT_GAIN_RST;
      retryCfg_ff <= RETRY_CNT_RST;
      retryDelay_ff <= RETRY_DLY_RST;
      saving_ff <= SAVING_RST;
      magTime_ff <= MAG_TIME_RST;
      rating_ff <= RATING_RST;
      motor_ff <= motorDefaults(RATING_RST);
      outFunc_ff <= OUT_FUNC_RST;
      relayFunc_ff <= RELAY_FUNC_RST;
    end else if (ce && busReq.wr) begin
      case (busReq.addr)
        OFS_SEARCH_CFG: begin
          searchMask_ff <= busReq.wdata[3:0];
          ctrlMode_ff <= 2'(clampW({6'h0, busReq.wdata[13:4]}, 16'h0, MODE_MAX));
        end
        OFS_CUR_LIMIT: curLimit_ff <= clampW(busReq.wdata, CUR_LIMIT_MIN, CUR_LIMIT_MAX);
        OFS_PROP_GAIN: propGain_ff <= clampW(busReq.wdata, 16'h0, PROP_GAIN_MAX);
        OFS_INT_GAIN: intGain_ff <= clampW(busReq.wdata, 16'h0, INT_GAIN_MAX);
        OFS_RETRY_CNT: retryCfg_ff <= clampW(busReq.wdata, 16'h0, RETRY_CNT_MAX);
        OFS_RETRY_DLY: retryDelay_ff <= clampW(busReq.wdata, 16'h0, RETRY_DLY_MAX);
        OFS_SAVING: saving_ff <= clampW(busReq.wdata, 16'h0, SAVING_MAX);
        OFS_MAG_TIME: magTime_ff <= clampW(busReq.wdata, 16'h0, MAG_TIME_MAX);
        OFS_RATING: begin
          rating_ff <= clampW(busReq.wdata, 16'h0, RATING_MAX);
          motor_ff <= motorDefaults(clampW(busReq.wdata, 16'h0, RATING_MAX));
        end
        OFS_SLIP: motor_ff.slip <= busReq.wdata;
        OFS_RATED_CUR: motor_ff.cur <= busReq.wdata;
        OFS_NOLOAD_CUR: motor_ff.noLoad <= busReq.wdata;
        OFS_STATOR_R: motor_ff.rs <= busReq.wdata;
        OFS_LEAK_L: motor_ff.ls <= busReq.wdata;
        OFS_OUT_FUNC: begin
          outFunc_ff <= busReq.wdata[4:0];
          relayFunc_ff <= busReq.wdata[12:8];
        end
        default: ;
      endcase
    end
  end

  // Drive sequence: magnetize, search, run, trip and restart wait
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= ST_IDLE;
      freq_ff <= 16'h0;
      volt_ff <= 16'h0;
      savedFreq_ff <= 16'h0;
      goalFreq_ff <= 16'h0;
      timer_ff <= 16'h0;
      integ_ff <= 24'sh0;
      uvTrip_ff <= 1'b0;
    end else if (ce) begin
      if (emgEv || lossEv) begin
        state_ff <= ST_TRIP;
        savedFreq_ff <= (state_ff == ST_RWAIT) ? savedFreq_ff : freq_ff;
        freq_ff <= 16'h0;
        volt_ff <= 16'h0;
        uvTrip_ff <= lossEv;
      end else if (faultEv) begin
        savedFreq_ff <= freq_ff;
        freq_ff <= 16'h0;
        volt_ff <= 16'h0;
        timer_ff <= retryDelay_ff;
        state_ff <= (remaining_ff != 4'h0 && !inhibit_ff) ? ST_RWAIT : ST_TRIP;
      end else if (stopCmd && busy) begin
        state_ff <= ST_IDLE;
        freq_ff <= 16'h0;
        volt_ff <= 16'h0;
      end else begin
        unique case (state_ff)
          ST_IDLE: begin
            if (startCmd) begin
              goalFreq_ff <= targetFreq;
              timer_ff <= (ctrlMode_ff == MODE_VECTOR) ? magTime_ff : 16'h0;
              state_ff <= ST_MAG;
            end
          end
          ST_MAG: begin
            if (timer_ff == 16'h0) begin
              integ_ff <= 24'sh0;
              if (searchMask_ff[SS_POWERON]) begin
                freq_ff <= goalFreq_ff;
                volt_ff <= 16'h0;
                state_ff <= ST_SEARCH;
              end else begin
                freq_ff <= 16'h0;
                state_ff <= ST_RUN;
              end
            end else if (tenthTick_ff) begin
              timer_ff <= timer_ff - 16'h1;
            end
          end
          ST_SEARCH: begin
            if (msTick_ff) begin
              integ_ff <= integ_ff + 24'(piErr);
              if (overLimit) begin
                freq_ff <= (freq_ff > FREQ_STEP) ? freq_ff - FREQ_STEP : 16'h0;
              end else if (voltSum >= {1'b0, vTarget}) begin
                volt_ff <= vTarget;
                state_ff <= ST_RUN;
              end else begin
                volt_ff <= voltSum[15:0];
              end
            end
          end
          ST_RUN: begin
            if (accelCmd) begin
              goalFreq_ff <= targetFreq;
              if (searchMask_ff[SS_ACCEL]) begin
                volt_ff <= 16'h0;
                integ_ff <= 24'sh0;
                state_ff <= ST_SEARCH;
              end
            end else if (msTick_ff) begin
              volt_ff <= vTarget;
              if (freq_ff < goalFreq_ff) begin
                freq_ff <= freq_ff + FREQ_STEP;
              end else if (freq_ff > goalFreq_ff) begin
                freq_ff <= freq_ff - FREQ_STEP;
              end
            end
          end
          ST_RWAIT: begin
            if (resetEv) begin
              state_ff <= searchMask_ff[SS_FAULT] ? ST_SEARCH : ST_IDLE;
              goalFreq_ff <= savedFreq_ff;
              freq_ff <= searchMask_ff[SS_FAULT] ? savedFreq_ff : 16'h0;
              integ_ff <= 24'sh0;
            end else if (attemptEv) begin
              freq_ff <= savedFreq_ff;
              goalFreq_ff <= savedFreq_ff;
              volt_ff <= 16'h0;
              integ_ff <= 24'sh0;
              state_ff <= ST_SEARCH;
            end else if (tenthTick_ff) begin
              timer_ff <= timer_ff - 16'h1;
            end
          end
          ST_TRIP: begin
            if (resetEv && !powerLoss) begin
              uvTrip_ff <= 1'b0;
              integ_ff <= 24'sh0;
              goalFreq_ff <= savedFreq_ff;
              freq_ff <= searchMask_ff[SS_FAULT] ? savedFreq_ff : 16'h0;
              state_ff <= searchMask_ff[SS_FAULT] ? ST_SEARCH : ST_IDLE;
            end else if (uvTrip_ff && !powerLoss) begin
              uvTrip_ff <= 1'b0;
              if (searchMask_ff[SS_POWER]) begin
                freq_ff <= savedFreq_ff;
                goalFreq_ff <= savedFreq_ff;
                volt_ff <= 16'h0;
                integ_ff <= 24'sh0;
                state_ff <= ST_SEARCH;
              end
            end
          end
        endcase
      end
    end
  end

  // Remaining restart attempts
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      remaining_ff <= RETRY_CNT_RST[3:0];
      resetTermPrev_ff <= 1'b0;
    end else if (ce) begin
      resetTermPrev_ff <= resetTerminal;
      if (resetEv) begin
        remaining_ff <= retryCfg_ff[3:0];
      end else if (attemptEv) begin
        remaining_ff <= remaining_ff - 4'h1;
      end else if (restoreDone_ff) begin
        remaining_ff <= retryCfg_ff[3:0];
      end
    end
  end

  // Halt by undervoltage or emergency blocks retries until a reset; the set wins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      inhibit_ff <= 1'b0;
    end else if (ce) begin
      if (emgEv || lossEv) begin
        inhibit_ff <= 1'b1;
      end else if (resetEv) begin
        inhibit_ff <= 1'b0;
      end
    end
  end

  // Trip-free window after a restart; any new halt cancels it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      restoreActive_ff <= 1'b0;
      restoreCnt_ff <= 9'h0;
      restoreDone_ff <= 1'b0;
    end else if (ce) begin
      restoreDone_ff <= 1'b0;
      if (faultEv || emgEv || lossEv) begin
        restoreActive_ff <= 1'b0;
      end else if (attemptEv) begin
        restoreActive_ff <= 1'b1;
        restoreCnt_ff <= RESTORE_TENTHS;
      end else if (restoreActive_ff && tenthTick_ff) begin
        restoreCnt_ff <= restoreCnt_ff - 9'h1;
        if (restoreCnt_ff == 9'h1) begin
          restoreActive_ff <= 1'b0;
          restoreDone_ff <= 1'b1;
        end
      end
    end
  end

  // Registered outputs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      drive_ff <= '0;
      progOut_ff <= 1'b0;
      progRelay_ff <= 1'b0;
      magnetizing_ff <= 1'b0;
    end else if (ce) begin
      magnetizing_ff <= (state_ff == ST_MAG) && (ctrlMode_ff == MODE_VECTOR);
      drive_ff.freq <= freq_ff;
      drive_ff.volt <= volt_ff;
      drive_ff.magCur <= (state_ff == ST_MAG && ctrlMode_ff == MODE_VECTOR) ?
                         motor_ff.noLoad : 16'h0;
      progOut_ff <= (outFunc_ff == FUNC_SEARCH) && (state_ff == ST_SEARCH);
      progRelay_ff <= (relayFunc_ff == FUNC_SEARCH) && (state_ff == ST_SEARCH);
    end
  end

  // Read data stands one cycle, zero otherwise and for unmapped addresses
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdData_ff <= 16'h0;
    end else if (ce) begin
      rdData_ff <= 16'h0;
      if (busReq.rd) begin
        case (busReq.addr)
          OFS_SEARCH_CFG: rdData_ff <= {2'h0, 8'h0, ctrlMode_ff, searchMask_ff};
          OFS_CUR_LIMIT: rdData_ff <= curLimit_ff;
          OFS_PROP_GAIN: rdData_ff <= propGain_ff;
          OFS_INT_GAIN: rdData_ff <= intGain_ff;
          OFS_RETRY_CNT: rdData_ff <= retryCfg_ff;
          OFS_RETRY_DLY: rdData_ff <= retryDelay_ff;
          OFS_SAVING: rdData_ff <= saving_ff;
          OFS_MAG_TIME: rdData_ff <= magTime_ff;
          OFS_RATING: rdData_ff <= rating_ff;
          OFS_SLIP: rdData_ff <= motor_ff.slip;
          OFS_RATED_CUR: rdData_ff <= motor_ff.cur;
          OFS_NOLOAD_CUR: rdData_ff <= motor_ff.noLoad;
          OFS_STATOR_R: rdData_ff <= motor_ff.rs;
          OFS_LEAK_L: rdData_ff <= motor_ff.ls;
          OFS_STATUS: rdData_ff <= {4'h0, remaining_ff, 1'b0, restoreActive_ff, inhibit_ff,
                                    uvTrip_ff, 1'b0, state_ff};
          OFS_OUT_FUNC: rdData_ff <= {3'h0, relayFunc_ff, 3'h0, outFunc_ff};
          default: rdData_ff <= 16'h0;
        endcase
      end
    end
  end

  assign rdData = rdData_ff;
  assign drive = drive_ff;
  assign programmableOutput = progOut_ff;
  assign programmableRelay = progRelay_ff;
  assign undervoltageTrip = uvTrip_ff;
  assign magnetizing = magnetizing_ff;

endmodule : ssar_ctrl

// ### verif/ssar_motor_model.sv
/* Motor stand-in for ssar_ctrl.
   Assumes the bench raises overload only where it wants a stall. */
`timescale 1ns/10ps
module ssar_motor_model
  import ssar_pkg::*;
(
  // Clock and control
  input wire logic clk,
  input wire logic overload,
  // Drive side
  input wire ssar_drive_t drive,
  output ssar_word_t outCurrent
);
  // Light load draws little so a search can end
  always @(posedge clk) begin
    outCurrent <= overload ? 16'h0064 : (drive.volt >> 5);
  end
endmodule : ssar_motor_model

// ### verif/ssar_ctrl_monitor.sv
/* Port checker for ssar_ctrl.
   Assumes it is bound to every ssar_ctrl instance. */
`timescale 1ns/10ps
module ssar_ctrl_monitor
  import ssar_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Watched ports
  input wire ssar_bus_req_t busReq,
  input wire ssar_word_t rdData,
  input wire logic [DW-1:0] maxVolt,
  input wire logic powerLoss,
  input wire logic emergencyHalt,
  input wire ssar_drive_t drive,
  input wire logic programmableOutput,
  input wire logic undervoltageTrip,
  input wire logic magnetizing
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  // Three cycles let the entry value settle first
  sequence inSearch;
    programmableOutput [*3];
  endsequence
  sequence haltHeld;
    emergencyHalt ##1 emergencyHalt;
  endsequence
  chk_rd_slot: assert property (rdData != 16'h0 |-> $past(busReq.rd))
    else $error("read data outside its slot");
  chk_uv_cause: assert property ($rose(undervoltageTrip) |-> $past(powerLoss) || $past(powerLoss, 2))
    else $error("trip flag without power loss");
  chk_uv_hold: assert property (undervoltageTrip && $past(undervoltageTrip)
    |-> drive.freq == 16'h0 && drive.volt == 16'h0 && !programmableOutput)
    else $error("output not held in trip");
  chk_search_fdown: assert property (inSearch |-> drive.freq <= $past(drive.freq))
    else $error("frequency rose in search");
  chk_search_vup: assert property (inSearch |-> drive.volt >= $past(drive.volt))
    else $error("voltage fell in search");
  chk_volt_cap: assert property (drive.volt <= maxVolt)
    else $error("voltage above maximum");
  chk_halt_zero: assert property (haltHeld |=> drive.freq == 16'h0 && drive.volt == 16'h0)
    else $error("output kept after halt");
  chk_mag_still: assert property (magnetizing && $past(magnetizing) |-> drive.freq == 16'h0)
    else $error("frequency while magnetizing");
endmodule : ssar_ctrl_monitor

bind ssar_ctrl ssar_ctrl_monitor ssar_ctrl_monitor_i (.clk(clk), .arst_n(arst_n),
  .busReq(busReq), .rdData(rdData), .maxVolt(maxVolt), .powerLoss(powerLoss),
  .emergencyHalt(emergencyHalt), .drive(drive), .programmableOutput(programmableOutput),
  .undervoltageTrip(undervoltageTrip), .magnetizing(magnetizing));

// ### verif/tb.sv
/* Self-checking bench for ssar_ctrl.
   Assumes a 10-cycle tick so tenths last 1000 cycles. */
`timescale 1ns/10ps
module tb;
  import ssar_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic ce = 1'b1;
  logic overload = 1'b1;
  logic powerLoss = 1'b0, faultTrip = 1'b0, emergencyHalt = 1'b0, resetTerminal = 1'b0;
  logic rdPend = 1'b0;
  logic programmableOutput, programmableRelay, undervoltageTrip, magnetizing;
  ssar_bus_req_t busReq = '0;
  ssar_word_t rdData, outCurrent, rt;
  ssar_word_t tf = 16'h0100;
  logic [DW-1:0] maxVolt = 16'h03e8;
  ssar_drive_t drive;
  logic [31:0] ent;
  logic [31:0] expQ[$];
  int numErrors = 0;
  int checksDone = 0;
  // Reset defaults, then write, expected read-back
  localparam logic [7:0] DA[16] = '{8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20,
    8'h24, 8'h28, 8'h2c, 8'h30, 8'h34, 8'h38, 8'h40, 8'h44};
  localparam ssar_word_t DV[16] = '{16'h0064, 16'h0064, 16'h03e8, 16'h0000, 16'h000a, 16'h0000,
    16'h000a, 16'h0000, 16'h0009, 16'h0005, 16'h012c, 16'h36b0, 16'h2fa8, 16'h0000, 16'h110c, 16'h0};
  localparam logic [7:0] CA[11] = '{8'h04, 8'h08, 8'h0c, 8'h14, 8'h18, 8'h10, 8'h14, 8'h1c,
    8'h20, 8'h40, 8'h00};
  localparam ssar_word_t CW[11] = '{16'h0032, 16'hffff, 16'hffff, 16'h02bc, 16'h0028, 16'h0002,
    16'h0001, 16'h0001, 16'h0004, 16'h0f0f, 16'h003f};
  localparam ssar_word_t CE[11] = '{16'h0050, 16'h270f, 16'h0d05, 16'h0258, 16'h001e, 16'h0002,
    16'h0001, 16'h0001, 16'h0004, 16'h0f0f, 16'h003f};
  always #10 clk = ~clk;
  ssar_ctrl #(.TICK_CYC(10)) ssar_ctrl_i (.clk(clk), .arst_n(arst_n), .ce(ce), .busReq(busReq),
    .rdData(rdData), .outCurrent(outCurrent), .targetFreq(tf), .maxVolt(maxVolt),
    .powerLoss(powerLoss), .faultTrip(faultTrip), .emergencyHalt(emergencyHalt),
    .resetTerminal(resetTerminal), .drive(drive), .programmableOutput(programmableOutput),
    .programmableRelay(programmableRelay), .undervoltageTrip(undervoltageTrip),
    .magnetizing(magnetizing));
  ssar_motor_model ssar_motor_model_i (.clk(clk), .overload(overload), .drive(drive),
    .outCurrent(outCurrent));
  task automatic cmp(input string nm, input ssar_word_t e, input ssar_word_t g);
    checksDone++;
    if (g !== e) begin
      numErrors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp
  task automatic wr(input logic [7:0] a, input ssar_word_t d);
    @(posedge clk);
    busReq <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    busReq <= '0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input ssar_word_t e, input ssar_word_t m = 16'hffff);
    expQ.push_back({m, e});
    @(posedge clk);
    busReq <= '{a, 16'h0, 1'b0, 1'b1};
    @(posedge clk);
    busReq <= '0;
  endtask : rd
  // Bounded so a stuck search cannot hang the run
  task automatic waitPo(input logic v);
    repeat (20000) if (programmableOutput !== v) @(posedge clk);
    cmp("programmableOutput", 16'(v), 16'(programmableOutput));
  endtask : waitPo
  task automatic pulse(input logic isFault);
    @(posedge clk);
    faultTrip <= isFault;
    resetTerminal <= !isFault;
    @(posedge clk);
    faultTrip <= 1'b0;
    resetTerminal <= 1'b0;
  endtask : pulse
  task automatic conclude;
    if (numErrors == 0 && checksDone > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : conclude
  always @(posedge clk) begin
    if (rdPend) begin
      ent = expQ.pop_front();
      cmp("rdData", ent[15:0], rdData & ent[31:16]);
    end
    rdPend <= busReq.rd;
  end
  initial begin
    repeat (60000) @(posedge clk);
    numErrors++;
    conclude();
  end
  initial begin
    void'($urandom(14566));
    tf = 16'(16'h00c8 + $urandom % 800);
    rt = 16'($urandom % 11);
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk);
    rd(OFS_STATUS, 16'h0000);
    for (int i = 0; i < 16; i++) rd(DA[i], DV[i]);
    wr(OFS_RETRY_CNT, rt);
    rd(OFS_RETRY_CNT, rt);
    for (int i = 0; i < 11; i++) begin
      wr(CA[i], CW[i]);
      rd(CA[i], CE[i]);
    end
    rd(OFS_SLIP, 16'h0058);
    rd(OFS_LEAK_L, 16'h046b);
    wr(OFS_COMMAND, 16'h0001);
    repeat (2000) if (magnetizing !== 1'b1) @(posedge clk);
    repeat (2) @(posedge clk);
    cmp("magCur", 16'h00c8, drive.magCur);
    waitPo(1'b1);
    cmp("relay", 16'h0001, 16'(programmableRelay));
    repeat (100) @(posedge clk);
    cmp("volt", 16'h0000, drive.volt);
    cmp("freqDown", 16'h0001, 16'(drive.freq < tf));
    overload <= 1'b0;
    waitPo(1'b0);
    repeat (2) @(posedge clk);
    cmp("volt", 16'h02bc, drive.volt);
    rd(OFS_STATUS, 16'h0003, 16'h0007);
    powerLoss <= 1'b1;
    repeat (4) @(posedge clk);
    cmp("uvTrip", 16'h0001, 16'(undervoltageTrip));
    rd(OFS_STATUS, 16'h0035, 16'h0037);
    powerLoss <= 1'b0;
    waitPo(1'b1);
    waitPo(1'b0);
    pulse(1'b1);
    rd(OFS_STATUS, 16'h0025, 16'h0027);
    wr(OFS_COMMAND, 16'h0002);
    rd(OFS_STATUS, 16'h0200, 16'h0f20);
    waitPo(1'b0);
    pulse(1'b1);
    rd(OFS_STATUS, 16'h0204, 16'h0f07);
    waitPo(1'b1);
    rd(OFS_STATUS, 16'h0140, 16'h0f40);
    waitPo(1'b0);
    pulse(1'b1);
    waitPo(1'b1);
    waitPo(1'b0);
    pulse(1'b1);
    rd(OFS_STATUS, 16'h0005, 16'h0f07);
    pulse(1'b0);
    rd(OFS_STATUS, 16'h0200, 16'h0f00);
    waitPo(1'b1);
    waitPo(1'b0);
    // Accel request in run searches again because mask bit 0 is set
    wr(OFS_COMMAND, 16'h0004);
    waitPo(1'b1);
    waitPo(1'b0);
    emergencyHalt <= 1'b1;
    repeat (4) @(posedge clk);
    cmp("freq", 16'h0000, drive.freq);
    rd(OFS_STATUS, 16'h0025, 16'h0027);
    emergencyHalt <= 1'b0;
    wr(OFS_COMMAND, 16'h0002);
    wr(OFS_COMMAND, 16'h0008);
    rd(OFS_STATUS, 16'h0000, 16'h0037);
    conclude();
  end
endmodule : tb
